// File: pkg/mdfm_regs.vh
`ifndef MDFM_REGS_VH
`define MDFM_REGS_VH
// ----------------------------------------------------------------------
// Frame layout and decode codes
// ----------------------------------------------------------------------
`define MDFM_FRAME_BITS      32
`define MDFM_PRE_MIN        32
`define MDFM_CLAUSE_SHORT   8'h00
`define MDFM_CLAUSE_LONG    8'h01
`define MDFM_CLAUSE_UNKNOWN 8'h02
`define MDFM_OP22_WRITE     8'h01
`define MDFM_OP22_READ      8'h02
`define MDFM_OP22_UNKNOWN   8'hff
`define MDFM_OP45_ADDR      8'h00
`define MDFM_OP45_WRITE     8'h01
`define MDFM_OP45_READ_ADV  8'h02
`define MDFM_OP45_READ      8'h03
`define MDFM_TIMEOUT_DEF    32'h0000_0fa0
`endif

// File: rtl/mdfm_mdio_frame_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "mdfm_regs.vh"
module mdfm_mdio_frame_monitor #(
  parameter [31:0] TIMEOUT_TICKS = `MDFM_TIMEOUT_DEF
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        clk_en,
  input  wire        mdc_pin,
  input  wire        mdio_pin,
  input  wire        bit_timing_en,
  output reg         rec_valid,
  input  wire        rec_ready,
  output reg  [31:0] rec_time_start,
  output reg  [31:0] rec_duration,
  output reg  [31:0] rec_data_offset,
  output reg  [7:0]  rec_clause,
  output reg  [7:0]  rec_opcode,
  output reg  [4:0]  first_address_field,
  output reg  [4:0]  second_address_field,
  output reg  [15:0] rec_data,
  output reg         turnaround_fault,
  output reg         rec_timeout,
  output reg         bit_valid,
  output reg  [31:0] bit_time,
  output reg  [5:0]  bit_index,
  output reg         bit_last
);
  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  reg  [1:0]  mdc_s_q;
  reg  [1:0]  mdio_s_q;
  reg         mdc_prev_q;
  wire        mdc_rise = mdc_s_q[1] & ~mdc_prev_q;
  wire        mdio_bit = mdio_s_q[1];

  // Both bus lines arrive from another clock domain, so each passes two
  // flip-flops before any logic reads it. The edge detector reads only the
  // second stage, which keeps a metastable first stage out of the decode.
  // The detector's history resets low, the parked level of the management
  // clock, so leaving reset never shows a false rising edge.
  // The data line resets high, the level its pull-up gives an idle bus.
  // The block has no output towards the bus at all: it only listens.
  // Two flops per pin; only the second stage feeds logic. Inputs only
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_s_q    <= 2'b00;
      mdio_s_q   <= 2'b11;
      mdc_prev_q <= 1'b0;
    end else if (clk_en) begin
      mdc_s_q    <= {mdc_s_q[0], mdc_pin};
      mdio_s_q   <= {mdio_s_q[0], mdio_pin};
      mdc_prev_q <= mdc_s_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // Free running tick counter and frame state
  // ----------------------------------------------------------------------
  // The tick counter runs free on every enabled clock and never resets
  // in mid-run, so all stamps share one time base. It wraps after 2^32
  // ticks; durations and offsets are differences, so they stay correct
  // across a wrap as long as one frame is shorter than the wrap period.
  // The frame state walks idle, preamble and body. A preamble shorter
  // than the minimum is dropped, since a frame cannot be located in it.
  // A body holds exactly 32 bits; fewer bits end only by the timeout.
  // The idle counter saturates, so a long quiet bus cannot alias to busy.
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_PRE  = 2'd1;
  localparam [1:0] ST_BODY = 2'd2;

  reg  [1:0]  state_q;
  reg  [31:0] tick_q;
  reg  [31:0] start_q;
  reg  [31:0] offset_q;
  reg  [31:0] last_rise_q;
  reg  [31:0] idle_q;
  reg  [5:0]  pre_cnt_q;
  reg  [5:0]  body_cnt_q;
  reg  [31:0] shift_q;
  reg         zero_seen_q;
  reg         have_prev_q;
  reg  [5:0]  prev_idx_q;
  reg         pend_q;
  reg         pend_to_q;

  wire        frame_done = (state_q == ST_BODY) && mdc_rise &&
                           (body_cnt_q == 6'd31);
  wire [31:0] since_start = tick_q - start_q;

  // Decoder helpers over the captured 32 bits after preamble.
  // The body is laid out MSB first as it was shifted in:
  //   bits 31..30 start field, 29..28 opcode,
  //   bits 27..23 first address field, 22..18 second address field,
  //   bits 17..16 turnaround, 15..0 data.
  // The body always begins with a 0, because the first 0 after the ones
  // is what ends the preamble; a start field of 1x therefore cannot be
  // captured and the unknown clause code never reaches a record.
  wire [1:0]  st_f  = shift_q[31:30];
  wire [1:0]  op_f  = shift_q[29:28];
  wire [1:0]  ta_f  = shift_q[17:16];
  reg  [7:0]  clause_c;
  reg  [7:0]  op_c;
  reg         ta_bad_c;

  // Clause and opcode decode; turnaround check depends on the opcode.
  always @* begin
    clause_c = `MDFM_CLAUSE_UNKNOWN;
    op_c     = `MDFM_OP22_UNKNOWN;
    ta_bad_c = 1'b0;
    if (st_f == 2'b01) begin
      clause_c = `MDFM_CLAUSE_SHORT;
      if (op_f == 2'b01)
        op_c = `MDFM_OP22_WRITE;
      else if (op_f == 2'b10)
        op_c = `MDFM_OP22_READ;
    end else if (st_f == 2'b00) begin
      clause_c = `MDFM_CLAUSE_LONG;
      case (op_f)
        2'b00:   op_c = `MDFM_OP45_ADDR;
        2'b01:   op_c = `MDFM_OP45_WRITE;
        2'b10:   op_c = `MDFM_OP45_READ_ADV;
        default: op_c = `MDFM_OP45_READ;
      endcase
    end
    // Writes must show 10; reads allow the released first bit as 1 or 0.
    if (op_f[1] == 1'b0 || (st_f == 2'b01 && op_f == 2'b01))
      ta_bad_c = (ta_f != 2'b10);
    else
      ta_bad_c = (ta_f[0] != 1'b0);
  end

  // Frame tracking: preamble, body shift, timestamps and idle timeout.
  // The start stamp is the tick of the first rising edge carrying a 1,
  // the offset is taken at the edge of the first 0 after the ones, and
  // the duration at the edge of the 32nd body bit. All three are tick
  // counts, so the bus rate never enters the arithmetic.
  // The timeout is checked only while a capture is open; an idle bus
  // between frames produces no records. A timed-out capture still
  // produces a record, marked so the host can discard its fields.
  // A stall by the record receiver holds the frame state and idle counter, so the
  // pending record is never overwritten; long stalls can miss frames.
  wire stall = pend_q & ~(~rec_valid | rec_ready);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      tick_q      <= 32'h0000_0000;
      start_q     <= 32'h0000_0000;
      offset_q    <= 32'h0000_0000;
      last_rise_q <= 32'h0000_0000;
      idle_q      <= 32'h0000_0000;
      pre_cnt_q   <= 6'h00;
      body_cnt_q  <= 6'h00;
      shift_q     <= 32'h0000_0000;
      zero_seen_q <= 1'b0;
      pend_q      <= 1'b0;
      pend_to_q   <= 1'b0;
    end else if (clk_en) begin
      tick_q <= tick_q + 32'h0000_0001;
      if (pend_q && (~rec_valid | rec_ready))
        pend_q <= 1'b0;
      if (!stall) begin
        if (mdc_rise)
          idle_q <= 32'h0000_0000;
        else if (idle_q != 32'hffff_ffff)
          idle_q <= idle_q + 32'h0000_0001;
        case (state_q)
          ST_IDLE: begin
            if (mdc_rise && mdio_bit) begin
              start_q   <= tick_q;
              pre_cnt_q <= 6'h01;
              state_q   <= ST_PRE;
            end
          end
          ST_PRE: begin
            if (mdc_rise) begin
              if (mdio_bit) begin
                if (pre_cnt_q != 6'h3f)
                  pre_cnt_q <= pre_cnt_q + 6'h01;
              end else if (pre_cnt_q >= 6'd`MDFM_PRE_MIN) begin
                offset_q    <= since_start;
                shift_q     <= {31'h0000_0000, mdio_bit};
                body_cnt_q  <= 6'h01;
                state_q     <= ST_BODY;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_BODY: begin
            if (mdc_rise) begin
              shift_q    <= {shift_q[30:0], mdio_bit};
              body_cnt_q <= body_cnt_q + 6'h01;
              if (frame_done) begin
                last_rise_q <= since_start;
                pend_q      <= 1'b1;
                pend_to_q   <= 1'b0;
                state_q     <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
        // Idle bus past the timeout closes an open capture early.
        if (state_q != ST_IDLE && !mdc_rise &&
            idle_q >= TIMEOUT_TICKS) begin
          last_rise_q <= since_start;
          pend_q      <= 1'b1;
          pend_to_q   <= 1'b1;
          state_q     <= ST_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry output buffer: skid register behind the record output
  // ----------------------------------------------------------------------
  // The record registers form entry one; the capture state is entry two
  // and stalls while it is full, so no finished record is lost.
  // A record is loaded in the cycle after the capture closes, because the
  // decode reads the shift register once the last bit has landed in it.
  // The fields of a timed-out record are whatever the partial shift held;
  // the turnaround flag is masked then, since no turnaround was seen.
  // While a record waits unaccepted, all its fields stand unchanged.
  // The trade-off is latency of one cycle against a wide output mux.
  wire load_rec = pend_q && (~rec_valid | rec_ready);
  wire [31:0] frame_word = shift_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rec_valid            <= 1'b0;
      rec_time_start       <= 32'h0000_0000;
      rec_duration         <= 32'h0000_0000;
      rec_data_offset      <= 32'h0000_0000;
      rec_clause           <= 8'h00;
      rec_opcode           <= 8'h00;
      first_address_field  <= 5'h00;
      second_address_field <= 5'h00;
      rec_data             <= 16'h0000;
      turnaround_fault     <= 1'b0;
      rec_timeout          <= 1'b0;
    end else if (clk_en) begin
      if (load_rec) begin
        rec_valid            <= 1'b1;
        rec_time_start       <= start_q;
        rec_duration         <= last_rise_q;
        rec_data_offset      <= offset_q;
        rec_clause           <= clause_c;
        rec_opcode           <= op_c;
        first_address_field  <= frame_word[27:23];
        second_address_field <= frame_word[22:18];
        rec_data             <= frame_word[15:0];
        turnaround_fault     <= ta_bad_c & ~pend_to_q;
        rec_timeout          <= pend_to_q;
      end else if (rec_ready) begin
        rec_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-bit timing stream
  // ----------------------------------------------------------------------
  // Each bit's time is emitted at the next rising edge, as the ticks from
  // the frame's first edge to that one; the last bit is emitted as zero.
  // The zero for the last bit follows once the capture has closed and
  // the previous pulse has dropped, so every pulse lasts one cycle and
  // two pulses never touch. A timed-out capture also ends with a zero.
  // The enable is sampled per edge; a user should change it only
  // between frames, or a frame's stream starts or stops part way.
  // Indexes count rising edges from the start of the preamble, so
  // index 0 is the first preamble bit and a full frame ends at 63.
  // The stream is not buffered: a host must take each pulse as it comes.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_valid   <= 1'b0;
      bit_time    <= 32'h0000_0000;
      bit_index   <= 6'h00;
      bit_last    <= 1'b0;
      have_prev_q <= 1'b0;
      prev_idx_q  <= 6'h00;
    end else if (clk_en) begin
      bit_valid <= 1'b0;
      if (!stall && bit_timing_en && state_q != ST_IDLE && mdc_rise) begin
        bit_valid   <= have_prev_q;
        bit_time    <= since_start;
        bit_index   <= prev_idx_q;
        bit_last    <= 1'b0;
        prev_idx_q  <= prev_idx_q + 6'h01;
        have_prev_q <= 1'b1;
      end else if (!stall && bit_timing_en && state_q == ST_IDLE &&
                   mdc_rise && mdio_bit) begin
        have_prev_q <= 1'b1;
        prev_idx_q  <= 6'h00;
      end else if (have_prev_q && state_q == ST_IDLE && !bit_valid) begin
        bit_valid   <= 1'b1;
        bit_time    <= 32'h0000_0000;
        bit_last    <= 1'b1;
        bit_index   <= prev_idx_q;
        have_prev_q <= 1'b0;
        prev_idx_q  <= 6'h00;
      end
    end
  end
endmodule // mdfm_mdio_frame_monitor
`default_nettype wire

// File: test/mdfm_peer.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------
// Station manager model on the observed bus
// -----------------------------------------
module mdfm_peer (
  output var logic mdc,
  output var logic mdio
);
  // Idle bus: clock parked low, data held up by the pull-up.
  initial begin
    mdc = 1'b0;
    mdio = 1'b1;
  end
  // Sends 32 preamble ones and then nbits of body, MSB first.
  // The odd start delay keeps the link edges off the sample clock edges.
  task automatic send(input logic [31:0] body, input int nbits);
    int n;
    #37;
    for (n = 0; n < 32 + nbits; n++) begin
      mdio = (n < 32) ? 1'b1 : body[63 - n];
      #400 mdc = 1'b1;
      #400 mdc = 1'b0;
    end
    mdio = 1'b1; // Released line returns to the pull-up level.
  endtask
endmodule // mdfm_peer
`default_nettype wire

// File: test/mdfm_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mdfm_chk (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        mdc_pin,
  input wire logic        bit_timing_en,
  input wire logic        rec_valid,
  input wire logic        rec_ready,
  input wire logic [31:0] rec_duration,
  input wire logic [31:0] rec_data_offset,
  input wire logic [7:0]  rec_clause,
  input wire logic [7:0]  rec_opcode,
  input wire logic [15:0] rec_data,
  input wire logic        rec_timeout,
  input wire logic        bit_valid,
  input wire logic [31:0] bit_time,
  input wire logic [5:0]  bit_index,
  input wire logic        bit_last
);
  logic [31:0] prev_q;
  // Last reported bit time, so later bits can be ordered against it.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) prev_q <= 32'h0;
    else if (bit_valid) prev_q <= bit_time;
  end
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_held; rec_valid && !rec_ready; endsequence
  sequence s_still;
    rec_valid && $stable(rec_clause) && $stable(rec_data)
      && $stable(rec_duration);
  endsequence
  a_rec_hold_stable: assert property (s_held |=> s_still)
    else $error("held record moved");
  a_last_bit_zero: assert property (bit_valid && bit_last |-> bit_time == 32'h0)
    else $error("last bit time not zero");
  a_bit_time_rises: assert property (bit_valid && !bit_last
    && bit_index != 6'h0 |-> bit_time > prev_q) else $error("bit time order");
  a_bit_gated: assert property (bit_valid |-> bit_timing_en)
    else $error("bit time while disabled");
  a_bit_one_pulse: assert property (bit_valid |=> !bit_valid)
    else $error("bit pulse too long");
  a_clause_range: assert property (rec_valid |-> rec_clause <= 8'h02)
    else $error("clause code out of range");
  a_short_opcode: assert property (rec_valid && !rec_timeout
    && rec_clause == 8'h00 |-> rec_opcode inside {8'h01, 8'h02, 8'hff})
    else $error("short form opcode code");
  a_long_opcode: assert property (rec_valid && !rec_timeout
    && rec_clause == 8'h01 |-> rec_opcode <= 8'h03) else $error("long opcode");
  a_offset_first: assert property (rec_valid && !rec_timeout
    |-> rec_data_offset < rec_duration) else $error("offset after end");
  a_timeout_idle: assert property ($rose(rec_valid) && rec_timeout
    |-> !mdc_pin && !$past(mdc_pin, 8)) else $error("timeout on busy bus");
endmodule // mdfm_chk
bind mdfm_mdio_frame_monitor mdfm_chk u_chk (.*);
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdfm_regs.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rec_ready = 1'b0;
  logic        bte = 1'b0;
  logic        stall = 1'b0;
  wire         mdc, mdio, rv, taf, tmo, bv, bl;
  wire  [31:0] dur, ofs, btime;
  wire  [7:0]  cl, op;
  wire  [4:0]  a1, a2;
  wire  [15:0] dat;
  wire  [5:0]  bidx;
  logic [45:0] exp_q[$];
  logic [45:0] e;
  logic [31:0] b;
  integer      seed = 32'hd9f3e34b;
  integer      err_total = 0;
  integer      total_checks = 0;
  integer      i, k;
  // Short idle timeout keeps the run brief.
  mdfm_mdio_frame_monitor #(.TIMEOUT_TICKS(32'h32)) dut (
    .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .mdc_pin(mdc),
    .mdio_pin(mdio), .bit_timing_en(bte), .rec_valid(rv),
    .rec_ready(rec_ready), .rec_time_start(), .rec_duration(dur),
    .rec_data_offset(ofs), .rec_clause(cl), .rec_opcode(op),
    .first_address_field(a1), .second_address_field(a2),
    .rec_data(dat), .turnaround_fault(taf), .rec_timeout(tmo),
    .bit_valid(bv), .bit_time(btime), .bit_index(bidx), .bit_last(bl));
  mdfm_peer u_peer (.mdc(mdc), .mdio(mdio));
  // Sample clock, 100 ns period.
  always #50 clk = ~clk;
  // -----------------------------
  // Expectation and scoring
  // -----------------------------
  // Packs clause, opcode, addresses, data, fault and which fields count.
  function automatic [45:0] expect_rec(input [31:0] f);
    logic [7:0] c, o;
    logic       t;
    c = (f[31:30] == 2'b01) ? `MDFM_CLAUSE_SHORT :
        (f[31:30] == 2'b00) ? `MDFM_CLAUSE_LONG : `MDFM_CLAUSE_UNKNOWN;
    o = (f[31:30] == 2'b00) ? {6'h00, f[29:28]} :
        (f[29:28] == 2'b01) ? `MDFM_OP22_WRITE :
        (f[29:28] == 2'b10) ? `MDFM_OP22_READ : `MDFM_OP22_UNKNOWN;
    t = f[29] ? f[16] : (f[17:16] != 2'b10);
    return {c, o, f[27:18], f[15:0], t, 1'b0, ~f[31],
            ~f[31] & (f[30] ? ^f[29:28] : 1'b1)};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Scores a record on the edge where the host side takes it.
  always @(posedge clk) begin
    if (rv === 1'b1 && rec_ready === 1'b1) begin
      e = exp_q.pop_front();
      check("timeout", {31'h0, tmo}, {31'h0, e[2]});
      if (!e[2]) begin
        check("clause", {24'h0, cl}, {24'h0, e[45:38]});
        if (e[1]) check("opcode", {24'h0, op}, {24'h0, e[37:30]});
        check("address", {22'h0, a1, a2}, {22'h0, e[29:20]});
        check("data", {16'h0, dat}, {16'h0, e[19:4]});
        if (e[0]) check("turnaround", {31'h0, taf}, {31'h0, e[3]});
        check("offset", ofs, 32'h100);
        check("duration", dur, 32'h1f8);
      end
    end
  end
  // Random host stalls; a forced stall lets two records pile up.
  always @(posedge clk) rec_ready <= !stall && ($random(seed) & 1) != 0;
  // -----------------------------
  // Stimulus
  // -----------------------------
  // Start fields 00 and 01 with every opcode, a bad turnaround, then a cut frame.
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 18; i++) begin
      b = $random(seed);
      b[17:16] = (i == 16) ? 2'b11 : 2'b10;
      b[31:28] = (i == 16) ? 4'h5 : {1'b0, i[2:0]};
      exp_q.push_back((i == 17) ? 46'h4 : expect_rec(b));
      stall <= (i == 4 || i == 5);
      bte <= ($random(seed) & 1) != 0;
      @(posedge clk);
      u_peer.send(b, (i == 17) ? 12 : 32);
      if (i == 5) stall <= 1'b0;
      repeat (100) @(posedge clk);
    end
    stall <= 1'b0;
    for (k = 0; k < 2000 && exp_q.size() != 0; k++) @(posedge clk);
    if (exp_q.size() != 0) err_total++;
    give_verdict();
  end
  // Hang guard.
  initial begin
    #10000000;
    err_total++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
